// ### rtl/branch_predict_return_stack.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - near call pushes following address
// - near return predicts top, then pops
// - full stack push drops oldest entry
// - zero-displacement call leaves stack untouched
// - nonzero segment base adds two cycles
// - 64-bit mode ignores segment base
// - loop latency 7 or 8 cycles
// - far transfers get no prediction
// - taken prediction costs one fetch bubble
// - up to four instructions per cycle
module branch_predict_return_stack
  import bp_pkg::*;
(
  input  wire logic                      clk,          // core clock, 100 MHz
  input  wire logic                      rst_n,        // async reset, active low
  input  wire bp_pkg::dec_slot_t         decSlot,      // branch slot from decode
  input  wire logic [ISSUE_W-1:0]        groupValid,   // instructions in decode group
  input  wire logic                      longMode,     // core runs in 64-bit mode
  input  wire logic [ADDR_W-1:0]         csBase,       // code-segment base
  input  wire bp_pkg::redirect_t         redirect,     // misprediction from retire
  output bp_pkg::pred_t                  pred,         // prediction to fetch
  output logic                           fetchStall,   // fetch bubble or penalty
  output logic [ISSUE_W-1:0]             issueGrant,   // instructions accepted this cycle
  output logic                           loopBusy,     // counted loop in flight
  output logic                           loopDone      // counted loop latency elapsed
);
  import bp_pkg::*;

  // all state of this block
  typedef struct packed {
    pred_t              pred;       // registered prediction
    logic [CNT_W-1:0]   stallCnt;   // bubble / penalty cycles left
    logic [CNT_W-1:0]   loopCnt;    // loop latency cycles left
    logic               loopBusy;   // loop in flight
    logic               loopDone;   // one-cycle completion pulse
    logic [ISSUE_W-1:0] grant;      // accepted slots
    logic               stall;      // fetch held, registered copy of stallCnt != 0
  } bp_state_t;

  bp_state_t st_r;   // registered state
  bp_state_t st_nxt; // next state

  // far forms are never predicted; their target is unknown to fetch
  // shared by the slot decode and the checks below
  function automatic logic is_far(input br_kind_t k);
    return (k == BR_FAR_JUMP) || (k == BR_FAR_CALL) || (k == BR_FAR_RET)
        || (k == BR_SOFT_INT) || (k == BR_OVF_TRAP) || (k == BR_INT_RET);
  endfunction : is_far

  // stall length for a redirect, segment base counted only outside 64-bit mode
  function automatic logic [CNT_W-1:0] miss_penalty(input logic lm, input logic [ADDR_W-1:0] base);
    return (!lm && base != '0) ? BASE_PENALTY + CSBASE_EXTRA : BASE_PENALTY;
  endfunction : miss_penalty

  // stack control decoded from the slot
  logic               slotOk;      // slot valid and not stalled
  logic               nearCall;    // real call that records a return
  logic               nearRet;     // return consulting the stack
  logic               zeroCall;    // call with zero displacement, target is its own pc
  logic [ADDR_W-1:0]  rsTop;       // stack top
  logic               rsEmpty;     // stack empty
  logic               rsFull;      // stack full, watched by the checks
  logic [CNT_W-1:0]   missCost;    // penalty for current redirect

  assign slotOk   = decSlot.valid && (st_r.stallCnt == '0);
  assign zeroCall = (decSlot.kind == BR_CALL) && (decSlot.disp == '0);
  assign nearCall = slotOk && (decSlot.kind == BR_CALL) && !zeroCall;
  // a return on an empty stack still pops; the stack itself refuses to move
  assign nearRet  = slotOk && (decSlot.kind == BR_RET);
  assign missCost = miss_penalty(longMode, csBase);

  return_stack u_ras (
    .clk      (clk),
    .rst_n    (rst_n),
    .push     (nearCall),
    .pop      (nearRet),
    .pushAddr (decSlot.nextInstrPointer),
    .topAddr  (rsTop),
    .empty    (rsEmpty),
    .full     (rsFull)
  );

  // next state: prediction, stall counting, loop latency
  // the redirect branch sits last so that it wins over any slot's prediction and stall
  always_comb begin
    st_nxt          = st_r;
    st_nxt.pred     = '0;
    st_nxt.loopDone = 1'b0;
    st_nxt.grant    = (st_r.stallCnt == '0) ? groupValid : '0;

    // stall counter runs down every cycle
    if (st_r.stallCnt != '0) begin
      st_nxt.stallCnt = st_r.stallCnt - CNT_W'(1);
    end

    // counted loop latency; runs ahead of the slot decode so that
    // a fresh loop slot restarts the count instead of being overwritten
    if (st_r.loopBusy) begin
      if (st_r.loopCnt == CNT_W'(1)) begin
        st_nxt.loopBusy = 1'b0;
        st_nxt.loopDone = 1'b1;
      end else begin
        st_nxt.loopCnt = st_r.loopCnt - CNT_W'(1);
      end
    end

    // predictions for the current slot
    if (slotOk && !is_far(decSlot.kind)) begin
      case (decSlot.kind)
        // near call: taken, relative target
        BR_CALL: begin
          st_nxt.pred.valid  = 1'b1;
          st_nxt.pred.taken  = 1'b1;
          st_nxt.pred.target = decSlot.pc + decSlot.disp;
        end
        // near jump: taken, relative target
        BR_JUMP: begin
          st_nxt.pred.valid  = 1'b1;
          st_nxt.pred.taken  = 1'b1;
          st_nxt.pred.target = decSlot.pc + decSlot.disp;
        end
        // return: stack top, or the fallback target when empty
        BR_RET: begin
          st_nxt.pred.valid     = 1'b1;
          st_nxt.pred.taken     = 1'b1;
          st_nxt.pred.fromStack = !rsEmpty;
          st_nxt.pred.target    = rsEmpty ? decSlot.altTarget : rsTop;
        end
        // conditional: direction from the other predictor
        BR_COND: begin
          st_nxt.pred.valid  = 1'b1;
          st_nxt.pred.taken  = decSlot.dirTaken;
          st_nxt.pred.target = decSlot.dirTaken ? decSlot.pc + decSlot.disp
                                                : decSlot.nextInstrPointer;
        end
        BR_LOOP: begin
          // no prediction: resolved after its fixed latency
          st_nxt.loopBusy = 1'b1;
          st_nxt.loopCnt  = longMode ? LOOP_LAT_64 : LOOP_LAT_32;
        end
        // plain slots get nothing; far kinds are filtered out before this case
        default: begin
          st_nxt.pred = '0;
        end
      endcase
      // a taken prediction costs a fetch bubble, not-taken none
      if (st_nxt.pred.taken) begin
        st_nxt.stallCnt = TAKEN_BUBBLE;
      end
    end

    // retire redirect overrides the prediction and the stall count
    if (redirect.valid) begin
      st_nxt.pred     = '0;
      st_nxt.stallCnt = missCost;
    end

    // held in a flop so the stall output leaves a register directly
    st_nxt.stall = (st_nxt.stallCnt != '0);
  end

  // state register
  // reset clears prediction, counters and grant alike
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a field of the state register
  assign pred       = st_r.pred;
  assign fetchStall = st_r.stall;
  assign issueGrant = st_r.grant;
  assign loopBusy   = st_r.loopBusy;
  assign loopDone   = st_r.loopDone;

  // far transfers never come out with a prediction
  a_far_unpredicted: assert property (@(posedge clk) disable iff (!rst_n)
    (decSlot.valid && is_far(decSlot.kind)) |=> !pred.valid)
    else $error("far transfer received a prediction");

  // a real call leaves its return address on top
  a_call_push_top: assert property (@(posedge clk) disable iff (!rst_n)
    nearCall |=> (rsTop == $past(decSlot.nextInstrPointer)))
    else $error("call did not push return address");

  // a return on a loaded stack predicts the top entry
  a_ret_uses_top: assert property (@(posedge clk) disable iff (!rst_n)
    (nearRet && !rsEmpty && !redirect.valid) |=> (pred.target == $past(rsTop) && pred.fromStack))
    else $error("return did not predict stack top");

  // the zero-displacement call leaves the stack as it was
  a_zero_call_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && zeroCall && !redirect.valid) |=> ($stable(rsTop) && $stable(rsEmpty)))
    else $error("zero-displacement call changed stack");

  // nonzero base in 32-bit mode: three stall cycles; a later redirect restarts them
  a_cs_penalty: assert property (@(posedge clk) disable iff (!rst_n)
    (redirect.valid && !longMode && csBase != '0) |=> fetchStall [*3] ##1 (!fetchStall || $past(redirect.valid)
      || $past(redirect.valid, 2) || $past(redirect.valid, 3) || $past(pred.taken)))
    else $error("segment base penalty not three cycles");

  // 64-bit mode ignores the base: a single stall cycle
  a_long_no_extra: assert property (@(posedge clk) disable iff (!rst_n)
    (redirect.valid && longMode && !decSlot.valid) ##1 !redirect.valid |=> !fetchStall)
    else $error("64-bit mode paid segment base penalty");

  // done is raised at the seventh edge and seen at the next sample
  a_loop_latency32: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && decSlot.kind == BR_LOOP && !longMode && !loopBusy && !redirect.valid) |-> ##8 loopDone)
    else $error("loop latency not seven cycles");

  // every taken prediction shows its bubble
  a_taken_bubble: assert property (@(posedge clk) disable iff (!rst_n)
    pred.taken |-> fetchStall)
    else $error("taken prediction without fetch bubble");

  // not-taken prediction keeps fetch running
  a_nottaken_nobubble: assert property (@(posedge clk) disable iff (!rst_n)
    (pred.valid && !pred.taken && !$past(redirect.valid)) |-> !fetchStall)
    else $error("not-taken prediction stalled fetch");

  // nothing accepted while fetch is held
  a_grant_width: assert property (@(posedge clk) disable iff (!rst_n)
    fetchStall |=> (issueGrant == '0))
    else $error("instructions accepted during stall");

  // further guards on the prediction, stack, stall, loop and grant paths

  // a real call is taken toward its relative target
  a_call_target: assert property (@(posedge clk) disable iff (!rst_n)
    (nearCall && !redirect.valid)
      |=> (pred.taken && pred.target == $past(decSlot.pc) + $past(decSlot.disp)))
    else $error("call predicted wrong target");

  // a full stack gives up one entry on a return
  a_full_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (nearRet && rsFull) |=> !rsFull)
    else $error("return on full stack did not pop");

  // a return on an empty stack falls back to the other predictor
  a_empty_ret_alt: assert property (@(posedge clk) disable iff (!rst_n)
    (nearRet && rsEmpty && !redirect.valid)
      |=> (pred.valid && !pred.fromStack && pred.target == $past(decSlot.altTarget)))
    else $error("empty-stack return used wrong target");

  // zero-displacement call is still taken, never from the stack
  a_zero_call_pred: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && zeroCall && !redirect.valid)
      |=> (pred.taken && !pred.fromStack))
    else $error("zero-displacement call mispredicted");

  // a redirect wipes out the prediction of its own cycle
  a_redirect_cancels: assert property (@(posedge clk) disable iff (!rst_n)
    redirect.valid |=> !pred.valid)
    else $error("prediction survived a redirect");

  // zero segment base costs only the base stall
  a_base_penalty: assert property (@(posedge clk) disable iff (!rst_n)
    (redirect.valid && (longMode || csBase == '0)) ##1 !redirect.valid
      |=> !fetchStall)
    else $error("zero segment base paid extra penalty");

  // far transfers leave the stack alone
  a_far_no_push: assert property (@(posedge clk) disable iff (!rst_n)
    (decSlot.valid && is_far(decSlot.kind))
      |=> ($stable(rsTop) && $stable(rsEmpty)))
    else $error("far transfer changed the stack");

  // conditional branch follows the direction predictor
  a_cond_direction: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && decSlot.kind == BR_COND && !redirect.valid)
      |=> (pred.valid && pred.taken == $past(decSlot.dirTaken)))
    else $error("conditional prediction lost its direction");

  // unconditional jump is taken and pays its bubble
  a_jump_bubble: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && decSlot.kind == BR_JUMP && !redirect.valid)
      |=> (pred.taken && fetchStall))
    else $error("jump without taken bubble");

  // a slot offered during a stall is ignored
  a_stall_refuses: assert property (@(posedge clk) disable iff (!rst_n)
    (decSlot.valid && fetchStall) |=> !pred.valid)
    else $error("slot predicted during a stall");

  // the counted loop gets no prediction, only its latency
  a_loop_no_pred: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && decSlot.kind == BR_LOOP) |=> !pred.valid)
    else $error("counted loop received a prediction");

  // 64-bit mode: done is raised at the eighth edge, seen at the next sample
  a_loop_latency64: assert property (@(posedge clk) disable iff (!rst_n)
    (slotOk && decSlot.kind == BR_LOOP && longMode && !loopBusy && !redirect.valid)
      |-> ##9 loopDone)
    else $error("loop latency not eight cycles");

  // completion is a single-cycle pulse
  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    loopDone |=> !loopDone)
    else $error("loop completion held too long");

  // with no stall the group mask passes one cycle later
  a_grant_follows: assert property (@(posedge clk) disable iff (!rst_n)
    !fetchStall |=> (issueGrant == $past(groupValid)))
    else $error("accepted slots differ from decode group");

endmodule : branch_predict_return_stack
`default_nettype wire

// ### rtl/bp_pkg.sv
package bp_pkg;

  // widths fixed at their working values
  localparam int          ADDR_W        = 32;           // instruction address width
  localparam int          RAS_DEPTH     = 8;            // return stack depth
  localparam int          PTR_W         = 3;            // index width for the stack
  localparam int          CNT_W         = 4;            // penalty / latency counter width
  localparam int          ISSUE_W       = 4;            // instructions per cycle

  // timing counts in core cycles
  localparam logic [3:0]  LOOP_LAT_32   = 4'h7;         // counted-loop latency, 32-bit protected mode
  localparam logic [3:0]  LOOP_LAT_64   = 4'h8;         // counted-loop latency, 64-bit protected mode
  localparam logic [3:0]  BASE_PENALTY  = 4'h1;         // redirect stall with zero segment base
  localparam logic [3:0]  CSBASE_EXTRA  = 4'h2;         // extra stall with nonzero segment base
  localparam logic [3:0]  TAKEN_BUBBLE  = 4'h1;         // fetch bubble after a taken prediction

  // decoded branch class from the decode stage
  typedef enum logic [3:0] {
    BR_NONE,
    BR_COND,
    BR_JUMP,
    BR_CALL,
    BR_RET,
    BR_LOOP,
    BR_FAR_JUMP,
    BR_FAR_CALL,
    BR_FAR_RET,
    BR_SOFT_INT,
    BR_OVF_TRAP,
    BR_INT_RET
  } br_kind_t;

  // one instruction slot of the decode group
  typedef struct packed {
    logic                valid;                         // slot holds an instruction
    br_kind_t            kind;                          // branch class
    logic [ADDR_W-1:0]   pc;                            // address of the instruction
    logic [ADDR_W-1:0]   nextInstrPointer;              // address after it
    logic [ADDR_W-1:0]   disp;                          // relative displacement
    logic                dirTaken;                      // direction predictor says taken
    logic [ADDR_W-1:0]   altTarget;                     // target from the other predictor
  } dec_slot_t;

  // prediction answer toward fetch
  typedef struct packed {
    logic                valid;                         // a prediction is given
    logic                taken;                         // redirect fetch
    logic [ADDR_W-1:0]   target;                        // predicted target
    logic                fromStack;                     // target came from the return stack
  } pred_t;

  // misprediction report from retire
  typedef struct packed {
    logic                valid;                         // retire saw a misprediction
    logic [ADDR_W-1:0]   target;                        // correct target
  } redirect_t;

endpackage : bp_pkg

// ### rtl/return_stack.sv
`timescale 1ns/10ps
`default_nettype none
module return_stack
  import bp_pkg::*;
(
  input  wire logic                clk,        // core clock
  input  wire logic                rst_n,      // async reset, active low
  input  wire logic                push,       // store a return address
  input  wire logic                pop,        // consume the top entry
  input  wire logic [ADDR_W-1:0]   pushAddr,   // address to store
  output logic      [ADDR_W-1:0]   topAddr,    // current top entry
  output logic                     empty,      // nothing stored
  output logic                     full        // all entries hold addresses
);
  // circular store: overflow simply overwrites the oldest slot
  typedef struct packed {
    logic [RAS_DEPTH-1:0][ADDR_W-1:0] mem;      // entries
    logic [PTR_W-1:0]                 top;      // index of newest entry
    logic [PTR_W:0]                   count;    // live entries
  } ras_state_t;

  ras_state_t st_r;  // registered state
  ras_state_t st_nxt; // next state

  // push and pop together on a non-empty stack: replace the top entry in place
  always_comb begin
    st_nxt = st_r;
    if (push && pop && st_r.count != '0) begin
      st_nxt.mem[st_r.top] = pushAddr;
    end else if (push) begin
      st_nxt.top = st_r.top + PTR_W'(1);
      st_nxt.mem[st_nxt.top] = pushAddr;
      if (st_r.count != (PTR_W+1)'(RAS_DEPTH)) begin
        st_nxt.count = st_r.count + (PTR_W+1)'(1);
      end
    end else if (pop && st_r.count != '0) begin
      st_nxt.top = st_r.top - PTR_W'(1);
      st_nxt.count = st_r.count - (PTR_W+1)'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign topAddr = st_r.mem[st_r.top];
  assign empty   = (st_r.count == '0);
  assign full    = (st_r.count == (PTR_W+1)'(RAS_DEPTH));

  a_pop_empty_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (pop && !push && empty) |=> ($stable(st_r.top) && empty))
    else $error("pop on empty stack moved the pointer");

  a_push_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    (push && !pop && full) |=> (full && topAddr == $past(pushAddr)))
    else $error("overflow push lost newest entry");

endmodule : return_stack
`default_nettype wire

// ### tb/decode_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the fetch and decode stage: offers one branch slot at a time
module decode_model
  import bp_pkg::*;
(
  input  wire logic               clk,        // core clock
  input  wire logic               rst_n,      // async reset, active low
  input  wire bp_pkg::dec_slot_t  req,        // slot the bench wants sent
  input  wire logic               go,         // load req at this edge
  input  wire logic               fetchStall, // predictor refuses slots
  output bp_pkg::dec_slot_t       decSlot,    // slot toward the predictor
  output logic                    acc         // slot is taken at next edge
);
  // slot is consumed only when offered with no stall running
  assign acc = decSlot.valid & ~fetchStall;

  // a stalled slot stays put; an idle slot shows inverted fields so
  // that stale values cannot pass for a real instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      decSlot <= '0;
    end else if (decSlot.valid && fetchStall) begin
      decSlot <= decSlot;
    end else if (go) begin
      decSlot <= req;
    end else begin
      decSlot <= {1'b0, ~decSlot[$bits(dec_slot_t)-2:0]};
    end
  end
endmodule : decode_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bp_pkg::*;
  logic        clk;            // core clock
  logic        rst_n;          // reset, active low
  dec_slot_t   req;            // next slot for the model
  logic        go;             // model load strobe
  dec_slot_t   decSlot;        // slot into the predictor
  logic        acc;            // slot will be taken
  logic [3:0]  groupValid;     // random decode group mask
  logic        longMode;       // 64-bit mode
  logic [31:0] csBase;         // code-segment base
  redirect_t   redirect;       // retire misprediction pulse
  pred_t       pred;           // prediction out
  logic        fetchStall;     // bubble or penalty
  logic [3:0]  issueGrant;     // accepted instructions
  logic        loopBusy;       // counted loop running
  logic        loopDone;       // counted loop finished
  logic [31:0] rnd, gst;       // random states
  logic [3:0]  gvPrev;         // mask seen at last edge
  logic        stPrev;         // stall seen at last edge
  logic        armed;          // grant checking enabled
  logic [31:0] stk[$];         // expected return stack, newest last
  int          failures, checks_done;

  always #5 clk = ~clk;

  branch_predict_return_stack dut (.clk(clk), .rst_n(rst_n), .decSlot(decSlot), .groupValid(groupValid),
    .longMode(longMode), .csBase(csBase), .redirect(redirect), .pred(pred), .fetchStall(fetchStall),
    .issueGrant(issueGrant), .loopBusy(loopBusy), .loopDone(loopDone));
  decode_model fe (.clk(clk), .rst_n(rst_n), .req(req), .go(go), .fetchStall(fetchStall),
    .decSlot(decSlot), .acc(acc));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // expected prediction; also walks the stack model
  function automatic pred_t want(input dec_slot_t s);
    pred_t e;
    e = '0;
    e.valid = 1'b1;
    e.taken = 1'b1;
    e.target = s.pc + s.disp;
    case (s.kind)
      BR_COND: e.taken = s.dirTaken;
      BR_JUMP: ;
      BR_CALL: if (s.disp != '0) begin
        stk.push_back(s.nextInstrPointer);
        if (stk.size() > RAS_DEPTH) void'(stk.pop_front());
      end
      BR_RET: if (stk.size() != 0) begin
        e.target = stk.pop_back();
        e.fromStack = 1'b1;
      end else e.target = s.altTarget;
      default: e = '0;  // far kinds and loop get nothing
    endcase
    return e;
  endfunction : want

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_val

  // target is only meaningful when a redirect is predicted
  task automatic cmp_pred(input pred_t g, input pred_t e);
    checks_done++;
    if (g.valid !== e.valid || g.taken !== e.taken || g.fromStack !== e.fromStack ||
        (e.taken && g.target !== e.target)) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_pred

  // counts stall cycles from the current falling edge
  task automatic stall_len(input logic [31:0] exp);
    int c;
    c = 0;
    while (fetchStall === 1'b1 && c < 8) begin
      c++;
      @(negedge clk);
    end
    cmp_val(c, exp);
  endtask : stall_len

  // sends one slot, checks its prediction and bubble
  task automatic slot(input br_kind_t k, input logic [31:0] d, input logic dt);
    dec_slot_t s;
    pred_t e;
    int n;
    rnd = lfsr(rnd);
    s.valid = 1'b1;
    s.kind = k;
    s.pc = rnd;
    s.nextInstrPointer = rnd + 32'h4;
    s.disp = d;
    s.dirTaken = dt;
    rnd = lfsr(rnd);
    s.altTarget = rnd;
    e = want(s);
    @(posedge clk);
    req <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    @(negedge clk);
    while (acc !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    cmp_val({31'h0, acc}, 32'h1);
    @(negedge clk);
    cmp_pred(pred, e);
    stall_len(e.taken ? TAKEN_BUBBLE : 4'h0);
  endtask : slot

  // misprediction pulse, then measure the penalty
  task automatic kick(input logic lm, input logic [31:0] cs);
    @(posedge clk);
    longMode <= lm;
    csBase <= cs;
    @(posedge clk);
    redirect <= '{valid: 1'b1, target: rnd};
    @(posedge clk);
    redirect <= '0;
    @(negedge clk);
    stall_len(BASE_PENALTY + ((cs != '0 && !lm) ? CSBASE_EXTRA : 4'h0));
  endtask : kick

  // counted loop latency in one mode
  task automatic lp(input logic lm);
    int c;
    @(posedge clk);
    longMode <= lm;
    slot(BR_LOOP, 32'h0, 1'b0);
    cmp_val({31'h0, loopBusy}, 32'h1);
    c = 0;
    while (loopDone !== 1'b1 && c < 20) begin
      @(negedge clk);
      c++;
    end
    cmp_val(c, lm ? LOOP_LAT_64 : LOOP_LAT_32);
    cmp_val({31'h0, loopBusy}, 32'h0);
  endtask : lp

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // random group mask every cycle; grant follows last mask unless stalled
  always @(posedge clk) begin
    gvPrev <= groupValid;
    stPrev <= fetchStall;
    gst = lfsr(gst);
    groupValid <= gst[3:0];
  end
  always @(negedge clk) if (armed) cmp_val({28'h0, issueGrant}, stPrev ? 32'h0 : {28'h0, gvPrev});

  initial begin
    #300000;
    failures++;
    end_sim();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; req = '0; go = 1'b0; longMode = 1'b0; csBase = '0; redirect = '0;
    groupValid = '0; rnd = 32'h36bd; gst = 32'h36bd; armed = 1'b0; failures = 0; checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp_pred(pred, '0);
    repeat (3) @(posedge clk);
    armed = 1'b1;
    repeat (10) slot(BR_CALL, rnd | 32'h4, 1'b0);
    slot(BR_CALL, 32'h0, 1'b0);
    for (int i = 6; i < 12; i++) slot(br_kind_t'(i), rnd | 32'h4, 1'b0);
    repeat (9) slot(BR_RET, rnd, 1'b0);
    slot(BR_CALL, rnd | 32'h4, 1'b0);
    slot(BR_RET, rnd, 1'b0);
    repeat (8) slot(BR_COND, rnd | 32'h4, rnd[5]);
    slot(BR_JUMP, rnd | 32'h4, 1'b0);
    kick(1'b0, 32'h0);
    kick(1'b0, rnd | 32'h10);
    kick(1'b1, rnd | 32'h10);
    lp(1'b0);
    lp(1'b1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
